// [rtl/ubc_pkg.sv]
// Package with the register map, field layout and bus-cycle carrier of the break unit
package ubc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [31:0] IDX_BRK_ADDR_A_HI = 32'hFFFFFF40;
	localparam logic [31:0] IDX_BRK_ADDR_A_LO = 32'hFFFFFF42;
	localparam logic [31:0] IDX_BRK_AMSK_A_HI = 32'hFFFFFF44;
	localparam logic [31:0] IDX_BRK_AMSK_A_LO = 32'hFFFFFF46;
	localparam logic [31:0] IDX_BRK_COND_A = 32'hFFFFFF48;
	localparam logic [31:0] IDX_BRK_ADDR_B_HI = 32'h0FFFFF60;
	localparam logic [31:0] IDX_BRK_ADDR_B_LO = 32'h0FFFFF62;
	localparam logic [31:0] IDX_BRK_AMSK_B_HI = 32'h0FFFFF64;
	localparam logic [31:0] IDX_BRK_AMSK_B_LO = 32'h0FFFFF66;
	localparam logic [31:0] IDX_BRK_COND_B = 32'h0FFFFF68;
	localparam logic [31:0] IDX_BRK_DATA_B_HI = 32'hFFFFFF70;
	localparam logic [31:0] IDX_BRK_DMSK_B_HI = 32'hFFFFFF74;
	localparam logic [31:0] IDX_BRK_STAT = 32'hFFFFFF80;
	localparam logic [31:0] IDX_BRK_IMSK = 32'hFFFFFF82;

	// Only the low index bits are decoded inside the block window
	localparam int IDX_DEC_W = 8;
	localparam int ADR_IDX_LSB = 2;

	// Cycle condition fields
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 6;
	localparam int FD_HI = 5;
	localparam int FD_LO = 4;
	localparam int DIR_HI = 3;
	localparam int DIR_LO = 2;
	localparam int SZ_HI = 1;
	localparam int SZ_LO = 0;
	localparam int COND_W = 8;
	localparam logic [1:0] SEL_OFF = 2'h0;

	// Status and mask bits
	localparam int STAT_A = 0;
	localparam int STAT_B = 1;
	localparam int STAT_W = 2;

	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	// One internal bus cycle as seen by the break unit
	typedef struct packed {
		logic valid;
		logic is_cpu;
		logic is_fetch;
		logic is_write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] data;
	} ubc_cycle_t;

endpackage

// [rtl/ubc_cyc_match.sv]
// Bus-cycle type comparator shared by both break channels
module ubc_cyc_match
	import ubc_pkg::*;
(
	// Condition and observed cycle
	input wire logic [15:0] cond_i,
	input wire ubc_cycle_t cyc_i,
	// Result
	output logic hit_o
);

	// Two-bit select: bit 0 picks the first kind, bit 1 the second, 00 none
	function automatic logic sel2(input logic [1:0] f, input logic first, input logic second);
		sel2 = (f[0] & first) | (f[1] & second);
	endfunction

	logic src_ok;
	logic fd_ok;
	logic dir_ok;
	logic sz_ok;

	// Each field gates the break on its own
	assign src_ok = sel2(cond_i[SRC_HI:SRC_LO], cyc_i.is_cpu, ~cyc_i.is_cpu);
	assign fd_ok = sel2(cond_i[FD_HI:FD_LO], cyc_i.is_fetch, ~cyc_i.is_fetch);
	assign dir_ok = sel2(cond_i[DIR_HI:DIR_LO], ~cyc_i.is_write, cyc_i.is_write);
	// Size 00 means any size; otherwise codes equal the cycle's size code
	assign sz_ok = (cond_i[SZ_HI:SZ_LO] == SEL_OFF) ||
		(cond_i[SZ_HI:SZ_LO] == cyc_i.size);

	assign hit_o = cyc_i.valid & src_ok & fd_ok & dir_ok & sz_ok;

endmodule

// [rtl/ubc_break_match.sv]
// Break condition registers, match logic and interrupt for channels A and B
// How it works
// - Source field: off, CPU, peripheral, both
// - Fetch/data field: off, fetch, data, both
// - Direction field: off, read, write, both
// - Size field: any, byte, word, longword
// - B address high holds bits 31-16
// - B address low holds bits 15-0
// - B address mask bit set skips bit
// - B data high holds data bits 31-16
// - B registers read/write, reset to zero
// - A address split into two halves
// - B data mask bit set skips bit
module ubc_break_match
	import ubc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Observed internal bus cycle
	input wire ubc_cycle_t bus_cyc_i,
	// Break interrupt request
	output logic irq_o
);

	// Index decode of one register
	function automatic logic idx_is(input logic [31:0] adr, input logic [31:0] idx);
		idx_is = adr[ADR_IDX_LSB +: IDX_DEC_W] == idx[IDX_DEC_W-1:0];
	endfunction

	// Byte-lane write of a 16-bit register
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [15:0] addr_a_hi_q;
	logic [15:0] addr_a_lo_q;
	logic [15:0] amsk_a_hi_q;
	logic [15:0] amsk_a_lo_q;
	logic [COND_W-1:0] cond_a_q;
	logic [15:0] addr_b_hi_q;
	logic [15:0] addr_b_lo_q;
	logic [15:0] amsk_b_hi_q;
	logic [15:0] amsk_b_lo_q;
	logic [COND_W-1:0] cond_b_q;
	logic [15:0] data_b_hi_q;
	logic [15:0] dmsk_b_hi_q;
	logic [STAT_W-1:0] stat_q;
	logic [STAT_W-1:0] imsk_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic match_a_q;
	logic match_b_q;

	logic req;
	logic wr_en;
	logic rd_stat;
	logic [31:0] rdat_d;
	logic [31:0] cmp_a;
	logic [31:0] msk_a;
	logic [31:0] cmp_b;
	logic [31:0] msk_b;
	logic type_a;
	logic type_b;
	logic addr_a_ok;
	logic addr_b_ok;
	logic data_b_ok;
	logic [15:0] cond_a_full;
	logic [15:0] cond_b_full;

	// A new request is taken only while no answer stands
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_en = req & wb_we_i;
	assign rd_stat = req & ~wb_we_i & idx_is(wb_adr_i, IDX_BRK_STAT);

	// Full comparison words built from the halves
	assign cmp_a = {addr_a_hi_q, addr_a_lo_q};
	assign msk_a = {amsk_a_hi_q, amsk_a_lo_q};
	assign cmp_b = {addr_b_hi_q, addr_b_lo_q};
	assign msk_b = {amsk_b_hi_q, amsk_b_lo_q};

	// Upper condition bits do not exist in storage
	assign cond_a_full = {8'h00, cond_a_q};
	assign cond_b_full = {8'h00, cond_b_q};

	// Cycle-type comparators for each channel
	ubc_cyc_match u_type_a (
		.cond_i(cond_a_full),
		.cyc_i(bus_cyc_i),
		.hit_o(type_a)
	);

	ubc_cyc_match u_type_b (
		.cond_i(cond_b_full),
		.cyc_i(bus_cyc_i),
		.hit_o(type_b)
	);

	// A set mask bit takes that bit out of the compare
	assign addr_a_ok = ((bus_cyc_i.addr ^ cmp_a) & ~msk_a) == RD_ZERO;
	assign addr_b_ok = ((bus_cyc_i.addr ^ cmp_b) & ~msk_b) == RD_ZERO;
	assign data_b_ok = ((bus_cyc_i.data[31:16] ^ data_b_hi_q) & ~dmsk_b_hi_q) ==
		REG_RST;

	// Registered match: one cycle after the bus cycle, all conditions at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_a_q <= 1'b0;
			match_b_q <= 1'b0;
		end else begin
			match_a_q <= type_a & addr_a_ok;
			match_b_q <= type_b & addr_b_ok & data_b_ok;
		end
	end

	// Channel A condition registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_a_hi_q <= REG_RST;
			addr_a_lo_q <= REG_RST;
			amsk_a_hi_q <= REG_RST;
			amsk_a_lo_q <= REG_RST;
			cond_a_q <= REG_RST[COND_W-1:0];
		end else if (wr_en) begin
			if (idx_is(wb_adr_i, IDX_BRK_ADDR_A_HI)) begin
				addr_a_hi_q <= wr16(addr_a_hi_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_ADDR_A_LO)) begin
				addr_a_lo_q <= wr16(addr_a_lo_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_AMSK_A_HI)) begin
				amsk_a_hi_q <= wr16(amsk_a_hi_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_AMSK_A_LO)) begin
				amsk_a_lo_q <= wr16(amsk_a_lo_q, wb_dat_i, wb_sel_i);
			end
			// Only the low lane holds storage; high lane writes are dropped
			if (idx_is(wb_adr_i, IDX_BRK_COND_A) && wb_sel_i[0]) begin
				cond_a_q <= wb_dat_i[COND_W-1:0];
			end
		end
	end

	// Channel B condition registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_b_hi_q <= REG_RST;
			addr_b_lo_q <= REG_RST;
			amsk_b_hi_q <= REG_RST;
			amsk_b_lo_q <= REG_RST;
			cond_b_q <= REG_RST[COND_W-1:0];
			data_b_hi_q <= REG_RST;
			dmsk_b_hi_q <= REG_RST;
		end else if (wr_en) begin
			if (idx_is(wb_adr_i, IDX_BRK_ADDR_B_HI)) begin
				addr_b_hi_q <= wr16(addr_b_hi_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_ADDR_B_LO)) begin
				addr_b_lo_q <= wr16(addr_b_lo_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_AMSK_B_HI)) begin
				amsk_b_hi_q <= wr16(amsk_b_hi_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_AMSK_B_LO)) begin
				amsk_b_lo_q <= wr16(amsk_b_lo_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_COND_B) && wb_sel_i[0]) begin
				cond_b_q <= wb_dat_i[COND_W-1:0];
			end
			if (idx_is(wb_adr_i, IDX_BRK_DATA_B_HI)) begin
				data_b_hi_q <= wr16(data_b_hi_q, wb_dat_i, wb_sel_i);
			end
			if (idx_is(wb_adr_i, IDX_BRK_DMSK_B_HI)) begin
				dmsk_b_hi_q <= wr16(dmsk_b_hi_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Sticky status, cleared by a read; a match in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= '0;
		end else begin
			stat_q <= (rd_stat ? '0 : stat_q) | {match_b_q, match_a_q};
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imsk_q <= '0;
		end else if (wr_en && idx_is(wb_adr_i, IDX_BRK_IMSK) && wb_sel_i[0]) begin
			imsk_q <= wb_dat_i[STAT_W-1:0];
		end
	end

	// Level interrupt while any unmasked status bit stands
	assign irq_o = |(stat_q & imsk_q);

	// Read multiplexer; unmapped indices read zero
	always_comb begin
		rdat_d = RD_ZERO;
		if (idx_is(wb_adr_i, IDX_BRK_ADDR_A_HI)) rdat_d[15:0] = addr_a_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_ADDR_A_LO)) rdat_d[15:0] = addr_a_lo_q;
		if (idx_is(wb_adr_i, IDX_BRK_AMSK_A_HI)) rdat_d[15:0] = amsk_a_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_AMSK_A_LO)) rdat_d[15:0] = amsk_a_lo_q;
		if (idx_is(wb_adr_i, IDX_BRK_COND_A)) rdat_d[15:0] = cond_a_full;
		if (idx_is(wb_adr_i, IDX_BRK_ADDR_B_HI)) rdat_d[15:0] = addr_b_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_ADDR_B_LO)) rdat_d[15:0] = addr_b_lo_q;
		if (idx_is(wb_adr_i, IDX_BRK_AMSK_B_HI)) rdat_d[15:0] = amsk_b_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_AMSK_B_LO)) rdat_d[15:0] = amsk_b_lo_q;
		if (idx_is(wb_adr_i, IDX_BRK_COND_B)) rdat_d[15:0] = cond_b_full;
		if (idx_is(wb_adr_i, IDX_BRK_DATA_B_HI)) rdat_d[15:0] = data_b_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_DMSK_B_HI)) rdat_d[15:0] = dmsk_b_hi_q;
		if (idx_is(wb_adr_i, IDX_BRK_STAT)) rdat_d[STAT_W-1:0] = stat_q;
		if (idx_is(wb_adr_i, IDX_BRK_IMSK)) rdat_d[STAT_W-1:0] = imsk_q;
	end

	// Registered answer: one wait state, ack dropped after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= RD_ZERO;
		end else begin
			ack_q <= req;
			if (req) begin
				rdat_q <= wb_we_i ? RD_ZERO : rdat_d;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Checks on the design's own behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_cyc_seen;
		bus_cyc_i.valid;
	endsequence

	property p_src_off;
		(cond_a_q[SRC_HI:SRC_LO] == SEL_OFF) |=> !match_a_q;
	endproperty
	a_src_off: assert property (p_src_off) else $error("source off still broke");

	property p_src_cpu;
		s_cyc_seen and (cond_a_q[SRC_HI:SRC_LO] == 2'h1) and !bus_cyc_i.is_cpu |=> !match_a_q;
	endproperty
	a_src_cpu: assert property (p_src_cpu) else $error("CPU-only broke on peripheral");

	property p_fd_off;
		(cond_a_q[FD_HI:FD_LO] == SEL_OFF) |=> !match_a_q;
	endproperty
	a_fd_off: assert property (p_fd_off) else $error("fetch/data off still broke");

	property p_src_per;
		s_cyc_seen and (cond_a_q[SRC_HI:SRC_LO] == 2'h2) and bus_cyc_i.is_cpu |=> !match_a_q;
	endproperty
	a_src_per: assert property (p_src_per) else $error("peripheral-only hit CPU");

	property p_fd_fetch;
		s_cyc_seen and (cond_a_q[FD_HI:FD_LO] == 2'h1) and !bus_cyc_i.is_fetch |=> !match_a_q;
	endproperty
	a_fd_fetch: assert property (p_fd_fetch) else $error("fetch-only hit data");

	property p_dir_rd;
		s_cyc_seen and (cond_a_q[DIR_HI:DIR_LO] == 2'h1) and bus_cyc_i.is_write |=> !match_a_q;
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("read-only broke on write");

	property p_size;
		(cond_a_q[SZ_HI:SZ_LO] != SEL_OFF) and (cond_a_q[SZ_HI:SZ_LO] != bus_cyc_i.size)
			|=> !match_a_q;
	endproperty
	a_size: assert property (p_size) else $error("size mismatch broke");

	property p_addr_a;
		(((bus_cyc_i.addr ^ cmp_a) & ~msk_a) != RD_ZERO) |=> !match_a_q;
	endproperty
	a_addr_a: assert property (p_addr_a) else $error("A broke on other address");

	property p_addr_b;
		(((bus_cyc_i.addr ^ cmp_b) & ~msk_b) != RD_ZERO) |=> !match_b_q;
	endproperty
	a_addr_b: assert property (p_addr_b) else $error("B broke on unmasked miss");

	property p_data_b;
		(((bus_cyc_i.data[31:16] ^ data_b_hi_q) & ~dmsk_b_hi_q) != REG_RST) |=> !match_b_q;
	endproperty
	a_data_b: assert property (p_data_b) else $error("B broke on data miss");

	property p_b_all;
		type_b and addr_b_ok and data_b_ok |=> match_b_q ##1 stat_q[STAT_B];
	endproperty
	a_b_all: assert property (p_b_all) else $error("B full match not flagged");

	// Channel A full match: flagged one cycle later, sticky the cycle after
	sequence s_flag_a;
		match_a_q ##1 stat_q[STAT_A];
	endsequence

	property p_a_all;
		type_a and addr_a_ok |=> s_flag_a;
	endproperty
	a_a_all: assert property (p_a_all) else $error("A full match not flagged");

	// A status read with no match landing leaves nothing set
	property p_stat_clr;
		rd_stat and !match_a_q and !match_b_q |=> stat_q == '0;
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status read did not clear");

	property p_irq;
		// A mask write in the same cycle may legally withdraw the request
		match_a_q and imsk_q[STAT_A] and !wr_en |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("unmasked break gave no irq");

	property p_rst_zero;
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> (cmp_b == RD_ZERO) && (msk_b == RD_ZERO) && (data_b_hi_q == REG_RST);
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("B regs not zero at reset");

	property p_cond_hi;
		ack_q and !wb_we_i and idx_is(wb_adr_i, IDX_BRK_COND_A) |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_cond_hi: assert property (p_cond_hi) else $error("cond A upper bits not zero");

	property p_ack;
		req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not single one-cycle answer");

endmodule

// [tb/ubc_bus_model.sv]
// Behavioural source of internal bus cycles watched by the break unit
module ubc_bus_model
	import ubc_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Observed cycle
	output ubc_cycle_t cyc_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at start
	initial begin
		cyc_o = '0;
	end

	// One valid cycle; idle afterwards with flipped fields so stale values never match
	task automatic send(input logic [4:0] kind, input logic [31:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		cyc_o <= {1'b1, kind, adr, dat};
		@(posedge clk_i);
		cyc_o <= {1'b0, kind, ~adr, ~dat};
	endtask
endmodule

// [tb/test_ubc_break_match.sv]
// Register, cycle-type and address match test of the break unit
module test_ubc_break_match
	import ubc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h00000000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	ubc_cycle_t bus_cyc;
	logic irq_o;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic [4:0] kind;
	logic [7:0] cnd;
	logic h;
	logic [31:0] regs [5];

	// 125 MHz clock
	always #4 clk_i = ~clk_i;

	ubc_break_match i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.bus_cyc_i(bus_cyc), .irq_o(irq_o));
	ubc_bus_model i_model (.clk_i(clk_i), .cyc_o(bus_cyc));

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic single cycle; only the watchdog ends the wait for a dead slave
	task automatic wb(input logic we, input logic [31:0] idx, input logic [15:0] wd,
		output logic [31:0] rdat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx[29:0], 2'b00};
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, wd};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] idx, input logic [15:0] d);
		wb(1'b1, idx, d, rd);
	endtask

	task automatic rdc(input string what, input logic [31:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 16'h0000, rd);
		chk(what, exp, rd);
	endtask

	// One bus cycle, then irq and status (the read also clears the sticky bits)
	task automatic fire(input logic [4:0] k, input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] es, input logic ei);
		i_model.send(k, a, d);
		repeat (3) @(posedge clk_i);
		#1;
		chk("irq", {31'h00000000, ei}, {31'h00000000, irq_o});
		rdc("status", IDX_BRK_STAT, {30'h00000000, es});
	endtask

	// Expected channel A type match; kind is {cpu, fetch, write, size}
	function automatic logic hit_a(input logic [7:0] c, input logic [4:0] k);
		logic s;
		logic f;
		logic w;
		logic z;
		s = k[4] ? c[6] : c[7];
		f = k[3] ? c[4] : c[5];
		w = k[2] ? c[3] : c[2];
		z = (c[1:0] == 2'h0) || (c[1:0] == k[1:0]);
		return s & f & w & z;
	endfunction

	initial begin
		regs = '{IDX_BRK_ADDR_B_HI, IDX_BRK_ADDR_B_LO, IDX_BRK_AMSK_B_HI, IDX_BRK_AMSK_B_LO,
			IDX_BRK_DATA_B_HI};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset value, then two patterns so stuck bits show
		foreach (regs[i]) begin
			rdc("reg_rst", regs[i], 32'h00000000);
			wr(regs[i], 16'hFFFF);
			rdc("reg_ones", regs[i], 32'h0000FFFF);
			wr(regs[i], 16'h5AC3 + 16'(i));
			rdc("reg_pat", regs[i], 32'h00005AC3 + i);
		end
		wr(IDX_BRK_COND_A, 16'hFFFF);
		rdc("cond_a", IDX_BRK_COND_A, 32'h000000FF);
		wr(32'hFFFFFFFC, 16'h1234);
		rdc("unmapped", 32'hFFFFFFFC, 32'h00000000);
		// Channel A: every condition code against a spread of cycle kinds
		wr(IDX_BRK_IMSK, 16'h0003);
		wr(IDX_BRK_ADDR_A_HI, 16'h1234);
		wr(IDX_BRK_ADDR_A_LO, 16'h5678);
		for (int i = 0; i < 1024; i++) begin
			cnd = i[7:0];
			kind = i[9:5] ^ i[4:0];
			if (kind[1:0] == 2'h0) begin
				kind[1:0] = 2'h2;
			end
			wr(IDX_BRK_COND_A, {8'h00, cnd});
			h = hit_a(cnd, kind);
			fire(kind, 32'h12345678, 32'h0, {1'b0, h}, h);
		end
		wr(IDX_BRK_COND_A, 16'h00FF);
		fire(5'h1F, 32'h12345679, 32'h0, 2'h0, 1'b0);
		wr(IDX_BRK_COND_A, 16'h0000);
		// Channel B: address halves, address mask, data high and its mask
		wr(IDX_BRK_COND_B, 16'h00FF);
		// High mask still holds a test pattern that would hide address bits
		wr(IDX_BRK_AMSK_B_HI, 16'h0000);
		wr(IDX_BRK_ADDR_B_HI, 16'hA5A5);
		wr(IDX_BRK_ADDR_B_LO, 16'h0F0F);
		wr(IDX_BRK_AMSK_B_LO, 16'h00F0);
		wr(IDX_BRK_DATA_B_HI, 16'hBEEF);
		fire(5'h1F, 32'hA5A50F0F, 32'hBEEF0000, 2'h2, 1'b1);
		fire(5'h1F, 32'hA5A50F3F, 32'hBEEF0000, 2'h2, 1'b1);
		fire(5'h1F, 32'hA5A40F0F, 32'hBEEF0000, 2'h0, 1'b0);
		wr(IDX_BRK_AMSK_B_HI, 16'h0001);
		fire(5'h1F, 32'hA5A40F0F, 32'hBEEF0000, 2'h2, 1'b1);
		fire(5'h1F, 32'hA5A50F0E, 32'hBEEF0000, 2'h0, 1'b0);
		fire(5'h1F, 32'hA5A50F0F, 32'hBEEE0000, 2'h0, 1'b0);
		wr(IDX_BRK_DMSK_B_HI, 16'h0001);
		fire(5'h1F, 32'hA5A50F0F, 32'hBEEE1234, 2'h2, 1'b1);
		// Masked channel: status still set, no interrupt, cleared by the read
		wr(IDX_BRK_IMSK, 16'h0001);
		fire(5'h1F, 32'hA5A50F0F, 32'hBEEF0000, 2'h2, 1'b0);
		rdc("status_clr", IDX_BRK_STAT, 32'h00000000);
		stop_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end
endmodule
